// ===== fifo_status_pkg.sv
/*
 * fifo status and trigger gating: shared constants and types.
 * assumes: a single 250 mhz clock domain, 8-bit register reads and writes.
 */
package fifo_status_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] STATUS_ADDR      = 8'h00;
    localparam logic [7:0] TRIG_CFG_ADDR    = 8'h0a;
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [7:0] TRIG_CFG_RESET   = 8'h00;
    localparam logic [7:0] TRIG_CFG_WMASK   = 8'h3e;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int OVF_BIT      = 7;
    localparam int WMRK_BIT     = 6;
    localparam int CNT_MSB      = 5;
    localparam int TRIG_TRANS   = 5;
    localparam int TRIG_ORIENT  = 4;
    localparam int TRIG_PULSE   = 3;
    localparam int TRIG_FFMT    = 2;
    localparam int TRIG_VECM    = 1;
    localparam int TRIG_LSB     = 1;
    localparam int TRIG_NUM     = 5;

    // ****************************************************************
    // fifo sizing and modes
    // ****************************************************************
    localparam int          CNT_W      = 6;
    localparam logic [5:0]  FIFO_DEPTH = 6'h20;
    localparam logic [5:0]  CNT_ZERO   = 6'h00;
    localparam logic [5:0]  CNT_ONE    = 6'h01;
    localparam logic [7:0]  MODE_OFF   = 8'h00;
    localparam logic [7:0]  MODE_TRIG  = 8'h11;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_GATED = 3'b010,
        ST_FULL  = 3'b100
    } fill_state_e;

endpackage : fifo_status_pkg

// ===== fifo_count_if.sv
/*
 * fifo count carrier between the status top and the count tracker.
 * assumes: all signals on i_mclk.
 */
`timescale 1ns/1ns
interface fifo_count_if;
    logic       push;
    logic       pop;
    logic       gate;
    logic [5:0] count;
    logic       overflow;
    logic       gated;
    logic       stored;

    modport tracker (
        input  push,
        input  pop,
        input  gate,
        output count,
        output overflow,
        output gated,
        output stored
    );
    modport user (
        output push,
        output pop,
        output gate,
        input  count,
        input  overflow,
        input  gated,
        input  stored
    );
endinterface : fifo_count_if

// ===== fifo_count_tracker.sv
/*
 * tracks fifo fill count, overflow and trigger gating.
 * assumes: push and pop are one-cycle pulses from the sample path.
 */
`timescale 1ns/1ns
module fifo_count_tracker
    import fifo_status_pkg::*;
(
    input  wire logic   i_mclk,
    input  wire logic   i_rst,
    fifo_count_if.tracker cnt
);

    // ****************************************************************
    // fill state
    // ****************************************************************
    fill_state_e state_reg;
    fill_state_e state_next;
    logic [5:0]  count_reg;
    logic [5:0]  count_next;
    logic        ovf_reg;
    logic        ovf_next;
    logic        stored_next;
    logic        stored_reg;

    always_comb begin
        state_next  = state_reg;
        count_next  = count_reg;
        ovf_next    = ovf_reg;
        stored_next = 1'b0;
        unique case (state_reg)
            ST_RUN: begin
                if (cnt.gate) begin
                    state_next = ST_GATED;
                end else if (cnt.push) begin
                    stored_next = 1'b1;
                    if (count_reg == FIFO_DEPTH) begin
                        ovf_next = 1'b1;
                    end else begin
                        count_next = count_reg + CNT_ONE;
                    end
                end else if (cnt.pop && count_reg != CNT_ZERO) begin
                    count_next = count_reg - CNT_ONE;
                    ovf_next   = 1'b0;
                end
            end
            ST_GATED: begin
                // samples kept unchanged; only sample pops drain them
                if (cnt.pop && count_reg != CNT_ZERO) begin
                    count_next = count_reg - CNT_ONE;
                    ovf_next   = 1'b0;
                end
                if (!cnt.gate) begin
                    state_next = ST_RUN;
                end
            end
            ST_FULL: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg  <= ST_RUN;
            count_reg  <= CNT_ZERO;
            ovf_reg    <= 1'b0;
            stored_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            ovf_reg    <= ovf_next;
            stored_reg <= stored_next;
        end
    end

    assign cnt.count    = count_reg;
    assign cnt.overflow = ovf_reg;
    assign cnt.gated    = (state_reg == ST_GATED);
    assign cnt.stored   = stored_reg;

    a_gated_no_fill: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state_reg == ST_GATED) && !cnt.pop |=> count_reg == $past(count_reg))
        else $error("count moved while gated");

    a_count_bound: assert property (@(posedge i_mclk) disable iff (i_rst)
        count_reg <= FIFO_DEPTH)
        else $error("count above depth");

endmodule : fifo_count_tracker

// ===== fifo_status_trigger.sv
/*
 * fifo status register, trigger configuration and trigger gating.
 * assumes: register accesses arrive as one-cycle read and write strobes
 * from the serial interface; detector flags are levels on i_mclk.
 */
// Contract
// - fifo enabled shows fifo status at 00h
// - mode zero shows sample ready status
// - bits 5..0 give stored sample count
// - bit 7 overflow held while overflowed
// - bit 6 set while count at or above watermark
// - trigger mode bit 6 flags trigger event
// - status read clears fifo interrupt source
// - next stored sample re-sets source bit while overflow or bit 6 is set
// - enabled trigger event stops sample storing
// - gated fifo keeps prior samples unchanged
// - config bit 5 enables transient trigger
// - config bit 4 enables orientation trigger
// - bits 3..1 enable pulse, freefall, vector
`timescale 1ns/1ns
module fifo_status_trigger
    import fifo_status_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_fifo_mode,
    input  wire logic [5:0] i_watermark,
    input  wire logic [7:0] i_sample_ready_status_reg,
    input  wire logic       i_sample_push,
    input  wire logic       i_sample_pop,
    input  wire logic [4:0] i_event_flags,
    output logic [7:0]      o_reg_rdata,
    output logic            o_store_enable,
    output logic            o_src_fifo
);

    // ****************************************************************
    // count tracker
    // ****************************************************************
    fifo_count_if cnt ();

    fifo_count_tracker u_tracker (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .cnt    (cnt.tracker)
    );

    // ****************************************************************
    // trigger configuration and gating
    // ****************************************************************
    logic [7:0] trig_cfg_reg;
    logic [7:0] trig_cfg_next;
    logic       trig_hit_reg;
    logic       trig_hit_next;
    logic       src_fifo_reg;
    logic       src_fifo_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       trig_mode;
    logic       fire;
    logic       wmrk;
    logic       flag_any;
    logic       status_rd;
    logic [7:0] fifo_status;

    assign trig_mode = (i_fifo_mode == MODE_TRIG);
    // per-source enable: trans, orient, pulse, ffmt, vecm
    assign fire = trig_mode &&
        |(trig_cfg_reg[TRIG_LSB +: TRIG_NUM] & i_event_flags);

    always_comb begin
        trig_cfg_next = trig_cfg_reg;
        trig_hit_next = trig_hit_reg;
        if (i_reg_wr && i_reg_addr == TRIG_CFG_ADDR) begin
            // bits 5..1 are enables; bit 4 orient, 3..1 others
            trig_cfg_next = i_reg_wdata & TRIG_CFG_WMASK;
        end
        if (!trig_mode) begin
            trig_hit_next = 1'b0;
        end else if (fire) begin
            trig_hit_next = 1'b1;
        end
    end

    assign cnt.gate  = trig_hit_reg || fire;
    assign cnt.push  = i_sample_push;
    assign cnt.pop   = i_sample_pop;
    assign o_store_enable = !(trig_hit_reg || fire);

    // ****************************************************************
    // status register and interrupt source
    // ****************************************************************
    assign wmrk = trig_mode ? trig_hit_reg
                            : (cnt.count >= i_watermark);
    assign fifo_status = {cnt.overflow, wmrk, cnt.count};
    assign flag_any  = cnt.overflow || wmrk;
    assign status_rd = i_reg_rd && i_reg_addr == STATUS_ADDR &&
                       i_fifo_mode != MODE_OFF;

    always_comb begin
        src_fifo_next = src_fifo_reg;
        rdata_next    = rdata_reg;
        if (status_rd) begin
            src_fifo_next = 1'b0;
        end
        // a fresh sample with a flag pending wins over the read
        if (cnt.stored && flag_any) begin
            src_fifo_next = 1'b1;
        end
        if (i_reg_rd) begin
            if (i_reg_addr == STATUS_ADDR) begin
                // reading never touches the count tracker
                rdata_next = (i_fifo_mode == MODE_OFF) ?
                    i_sample_ready_status_reg :
                    fifo_status;
            end else if (i_reg_addr == TRIG_CFG_ADDR) begin
                rdata_next = trig_cfg_reg;
            end else begin
                rdata_next = STATUS_RESET;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            trig_cfg_reg <= TRIG_CFG_RESET;
            trig_hit_reg <= 1'b0;
            src_fifo_reg <= 1'b0;
            rdata_reg    <= STATUS_RESET;
        end else begin
            trig_cfg_reg <= trig_cfg_next;
            trig_hit_reg <= trig_hit_next;
            src_fifo_reg <= src_fifo_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_src_fifo  = src_fifo_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_status_read;
        status_rd && !(cnt.stored && flag_any);
    endsequence

    a_read_clears_src: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_status_read |=> !o_src_fifo)
        else $error("status read left source set");

    a_sample_sets_src: assert property (@(posedge i_mclk) disable iff (i_rst)
        cnt.stored && flag_any |=> o_src_fifo)
        else $error("source not re-set on sample");

    // trigger gating steps: enabled event seen, then storing held off
    sequence s_trig_fire;
        trig_mode && fire;
    endsequence

    sequence s_gate_held;
        !o_store_enable && cnt.gate;
    endsequence

    a_trigger_gates: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_trig_fire |-> s_gate_held ##1 (!trig_mode || !o_store_enable))
        else $error("store not gated on trigger");

    a_latch_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
        trig_hit_reg && trig_mode |=> trig_hit_reg)
        else $error("trigger latch dropped");

    a_store_open: assert property (@(posedge i_mclk) disable iff (i_rst)
        !trig_mode ##1 !trig_mode |-> o_store_enable)
        else $error("store gated outside trigger mode");

    a_mode_zero_view: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_reg_rd && i_reg_addr == STATUS_ADDR && i_fifo_mode == MODE_OFF
        |=> o_reg_rdata == $past(i_sample_ready_status_reg))
        else $error("mode zero status wrong");

    a_fifo_view: assert property (@(posedge i_mclk) disable iff (i_rst)
        status_rd |=> o_reg_rdata == $past(fifo_status))
        else $error("fifo status wrong");

    a_wmrk_level: assert property (@(posedge i_mclk) disable iff (i_rst)
        !trig_mode && cnt.count >= i_watermark |-> fifo_status[WMRK_BIT])
        else $error("watermark flag missing");

    a_trig_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
        trig_mode && fire |=> trig_mode |-> fifo_status[WMRK_BIT])
        else $error("trigger flag missing");

    a_cfg_write: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_reg_wr && i_reg_addr == TRIG_CFG_ADDR
        |=> trig_cfg_reg == ($past(i_reg_wdata) & TRIG_CFG_WMASK))
        else $error("config write lost");

    a_read_keeps_cnt: assert property (@(posedge i_mclk) disable iff (i_rst)
        status_rd && !i_sample_push && !i_sample_pop
        |=> cnt.count == $past(cnt.count))
        else $error("read changed count");

    a_ovf_held: assert property (@(posedge i_mclk) disable iff (i_rst)
        cnt.overflow && !i_sample_pop |=> cnt.overflow)
        else $error("overflow flag dropped");

    a_cfg_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
        !(i_reg_wr && i_reg_addr == TRIG_CFG_ADDR)
        |=> trig_cfg_reg == $past(trig_cfg_reg))
        else $error("config changed without write");

    a_cfg_read: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_reg_rd && i_reg_addr == TRIG_CFG_ADDR
        |=> o_reg_rdata == $past(trig_cfg_reg))
        else $error("config read wrong");

    a_unmapped_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_reg_rd && i_reg_addr != STATUS_ADDR && i_reg_addr != TRIG_CFG_ADDR
        |=> o_reg_rdata == STATUS_RESET)
        else $error("unmapped read not zero");

endmodule : fifo_status_trigger

// ===== fifo_host_model.sv
/*
 * host model: register reads and writes on the strobe bus.
 * assumes: strobes sampled on rising i_mclk, rdata valid after rd edge.
 */
`timescale 1ns/1ns
module fifo_host_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_reg_rdata,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd
);
    initial begin
        o_reg_addr = 8'hff;
        o_reg_wdata = 8'hff;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
    end

    // ****************************************************************
    // bus cycles; idle lines show the inverse of the last value
    // ****************************************************************
    task reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_mclk);
        o_reg_addr = addr;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(negedge i_mclk);
        o_reg_wr = 1'b0;
        o_reg_addr = ~addr;
        o_reg_wdata = ~data;
    endtask : reg_write

    task reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_mclk);
        o_reg_addr = addr;
        o_reg_rd = 1'b1;
        @(negedge i_mclk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~addr;
        data = i_reg_rdata;
    endtask : reg_read
endmodule : fifo_host_model

// ===== accel_fifo_status_trigger_bench.sv
/*
 * self-checking bench for the fifo status and trigger block.
 * assumes: inputs driven at falling i_mclk by the bench and host model.
 */
`timescale 1ns/1ns
module accel_fifo_status_trigger_bench import fifo_status_pkg::*;;
    logic       i_mclk;
    logic       i_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] fifo_mode;
    logic [7:0] ready_status;
    logic [5:0] watermark;
    logic       push;
    logic       pop;
    logic [4:0] event_flags;
    logic       store_enable;
    logic       src_fifo;
    int         miscompares;
    int         total_checks;

    fifo_status_trigger dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_fifo_mode(fifo_mode),
        .i_watermark(watermark), .i_sample_ready_status_reg(ready_status),
        .i_sample_push(push), .i_sample_pop(pop),
        .i_event_flags(event_flags), .o_reg_rdata(reg_rdata),
        .o_store_enable(store_enable), .o_src_fifo(src_fifo));

    fifo_host_model host_u (.i_mclk(i_mclk), .i_reg_rdata(reg_rdata),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task check(input string what, input logic [7:0] seen,
               input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task read_expect(input logic [7:0] addr, input logic [7:0] exp,
                     input string what);
        logic [7:0] data;
        host_u.reg_read(addr, data);
        check(what, data, exp);
    endtask : read_expect

    task pulse_n(input logic is_pop, input int n);
        repeat (n) begin
            @(negedge i_mclk);
            push = ~is_pop;
            pop = is_pop;
            @(negedge i_mclk);
            push = 1'b0;
            pop = 1'b0;
        end
        repeat (2) @(negedge i_mclk);
    endtask : pulse_n

    task pulse_reset;
        @(negedge i_mclk);
        i_rst = 1'b1;
        repeat (8) @(negedge i_mclk);
        i_rst = 1'b0;
    endtask : pulse_reset

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task sc_reset_view;
        ready_status = 8'ha5;
        read_expect(STATUS_ADDR, 8'ha5, "ready view");
        read_expect(TRIG_CFG_ADDR, TRIG_CFG_RESET, "cfg rst");
        read_expect(8'h33, 8'h00, "unmapped");
        host_u.reg_write(TRIG_CFG_ADDR, 8'hff);
        read_expect(TRIG_CFG_ADDR, TRIG_CFG_WMASK, "cfg mask");
        watermark = 6'h03;
        fifo_mode = 8'h01;
        read_expect(STATUS_ADDR, STATUS_RESET, "fifo view");
    endtask : sc_reset_view

    task sc_fill;
        watermark = 6'h03;
        pulse_n(1'b0, 2);
        check("src idle", {7'h00, src_fifo}, 8'h00);
        read_expect(STATUS_ADDR, 8'h02, "below wm");
        pulse_n(1'b0, 1);
        check("src set", {7'h00, src_fifo}, 8'h01);
        read_expect(STATUS_ADDR, 8'h43, "at wm");
        check("src clr", {7'h00, src_fifo}, 8'h00);
        read_expect(STATUS_ADDR, 8'h43, "reread");
        pulse_n(1'b0, 1);
        check("src again", {7'h00, src_fifo}, 8'h01);
        pulse_n(1'b0, 28);
        read_expect(STATUS_ADDR, 8'h60, "full");
        pulse_n(1'b0, 1);
        read_expect(STATUS_ADDR, 8'he0, "overflow");
        read_expect(STATUS_ADDR, 8'he0, "ovf held");
        pulse_n(1'b1, 1);
        read_expect(STATUS_ADDR, 8'h5f, "after pop");
    endtask : sc_fill

    task sc_trigger(input int k);
        pulse_reset;
        fifo_mode = MODE_TRIG;
        watermark = 6'h01;
        pulse_n(1'b0, 2);
        read_expect(STATUS_ADDR, 8'h02, "pre trig");
        host_u.reg_write(TRIG_CFG_ADDR, 8'h01 << k);
        read_expect(TRIG_CFG_ADDR, 8'h01 << k, "cfg bit");
        @(negedge i_mclk);
        event_flags = 5'h01 << (k % 5);
        #1;
        check("not gated", {7'h00, store_enable}, 8'h01);
        @(negedge i_mclk);
        event_flags = 5'h01 << (k - 1);
        #1;
        check("gated", {7'h00, store_enable}, 8'h00);
        pulse_n(1'b0, 1);
        read_expect(STATUS_ADDR, 8'h42, "trig flag");
        event_flags = 5'h00;
        pulse_n(1'b0, 1);
        read_expect(STATUS_ADDR, 8'h42, "frozen");
    endtask : sc_trigger

    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    initial begin
        #100000;
        miscompares++;
        close_out;
    end

    initial begin
        i_rst = 1'b1;
        fifo_mode = MODE_OFF;
        watermark = 6'h00;
        ready_status = 8'h00;
        push = 1'b0;
        pop = 1'b0;
        event_flags = 5'h00;
        miscompares = 0;
        total_checks = 0;
        pulse_reset;
        sc_reset_view;
        sc_fill;
        for (int k = 1; k <= TRIG_NUM; k++) begin
            sc_trigger(k);
        end
        close_out;
    end
endmodule : accel_fifo_status_trigger_bench
